//--- rf_framing_pkg.sv
// constants, field layout and carriers for the framing option registers
package rf_framing_pkg;

    // ------------------------------------------------------------
    // register map (plain port, printed offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] TYPEB_ALT_OFFSET = 8'h07;
    localparam logic [7:0] STREAM_MODE_OFFSET = 8'h08;
    localparam logic [7:0] AUX_DEF_OFFSET = 8'h09;

    localparam logic [7:0] TYPEB_ALT_RESET = 8'h00;
    localparam logic [7:0] STREAM_MODE_RESET = 8'h00;
    localparam logic [7:0] AUX_DEF_RESET = 8'h04;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MIN_RESP_DELAY_HI = 7;
    localparam int MIN_RESP_DELAY_LO = 6;
    localparam int NO_SOF_BIT = 5;
    localparam int NO_EOF_BIT = 4;
    localparam int EOF_WIDE_BIT = 3;
    localparam int PHASE_TOL_BIT = 2;
    localparam int PREAMBLE_LEN_HI = 1;
    localparam int PREAMBLE_LEN_LO = 0;

    localparam int SUBCARRIER_FREQ_HI = 6;
    localparam int SUBCARRIER_FREQ_LO = 5;
    localparam int REPORT_PULSES_HI = 4;
    localparam int REPORT_PULSES_LO = 3;
    localparam int MOD_PERIOD_B2 = 2;
    localparam int MOD_PERIOD_B0 = 0;

    localparam int CRC_SKIP_BIT = 7;
    localparam int CRC_FIFO_BIT = 6;
    localparam int TX_MOD_TYPE_BIT = 5;
    localparam int FIELD_DET_BIT = 4;
    localparam int TRISTATE_BIT = 3;
    localparam int RX_TOL_BIT = 2;
    localparam int FIELD_ON_N_HI = 1;
    localparam int FIELD_ON_N_LO = 0;

    // ------------------------------------------------------------
    // decoded figures
    // ------------------------------------------------------------
    localparam logic [6:0] MRD_LONG_FS = 7'h50;
    localparam logic [6:0] MRD_LOW_RATE_FS = 7'h40;
    localparam logic [6:0] MRD_HIGH_RATE_FS = 7'h20;
    localparam logic [3:0] EOF_MIN_ETU = 4'ha;
    localparam logic [3:0] EOF_NARROW_MAX_ETU = 4'hb;
    localparam logic [3:0] EOF_WIDE_MAX_ETU = 4'hc;
    localparam logic [6:0] PREAMBLE_BASE = 7'h30;
    localparam logic [6:0] PREAMBLE_STEP = 7'h10;
    localparam logic [7:0] SC_BASE_DIV = 8'h40;
    localparam logic [7:0] BPSK_BASE_DIV = 8'h10;
    localparam logic [7:0] MOD_BASE_DIV = 8'h80;
    localparam logic [3:0] PULSES_BASE = 4'h1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_s;

    typedef struct packed {
        logic set_default;
        logic rate_fc128;
        logic rate_ge_fc16;
        logic bpsk_stream;
        logic bpsk_fc32;
        logic typea_nfc_fc128;
        logic reqa_wupa_sent;
        logic anticoll_on;
        logic rx_frame_end;
        logic ook_mod_active;
        logic analog_preset;
        logic preset_am;
        logic preset_fd;
    } rf_ctx_s;

    typedef struct packed {
        logic [6:0] min_response_delay;
        logic min_response_valid;
        logic rx_no_sof;
        logic rx_no_eof;
        logic [3:0] eof_min_etu;
        logic [3:0] eof_max_etu;
        logic phase_change_tolerance;
        logic [6:0] preamble_len;
        logic [7:0] subcarrier_div;
        logic subcarrier_valid;
        logic [3:0] report_pulses;
        logic report_valid;
        logic [7:0] mod_period_div;
        logic mod_period_valid;
        logic crc_check;
        logic crc_to_fifo;
        logic tx_mod_type;
        logic field_detector_enable;
        logic rf_output_driver_tristate;
        logic rx_tol_bpsk;
        logic rx_tol_first_byte;
        logic [1:0] field_on_n;
    } cfg_s;

endpackage : rf_framing_pkg

//--- rf_framing_option_regs.sv
// framing option register bank with decoded configuration outputs
`timescale 1ns/1ns
// ------------------------------------------------------------
// ------------------------------------------------------------
module rf_framing_option_regs
    import rf_framing_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_s reg_req,
    input wire rf_ctx_s ctx,
    output logic [7:0] reg_rdata,
    output cfg_s cfg
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] typeb_alt_protocol_settings_q;
    logic [7:0] stream_mode_definition_q;
    logic [7:0] auxiliary_definition_q;
    logic [7:0] reg_rdata_q;
    logic auto_no_crc_q;
    cfg_s cfg_q;
    cfg_s cfg_d;

    logic wr_typeb;
    logic wr_stream;
    logic wr_aux;

    assign wr_typeb = reg_req.we && (reg_req.addr == TYPEB_ALT_OFFSET);
    assign wr_stream = reg_req.we && (reg_req.addr == STREAM_MODE_OFFSET);
    assign wr_aux = reg_req.we && (reg_req.addr == AUX_DEF_OFFSET);

    // set default outranks a write in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst || ctx.set_default) begin
            typeb_alt_protocol_settings_q <= TYPEB_ALT_RESET;
        end else if (wr_typeb) begin
            typeb_alt_protocol_settings_q <= reg_req.wdata;
        end
    end

    // only power-up reset touches this one
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stream_mode_definition_q <= STREAM_MODE_RESET;
        end else if (wr_stream) begin
            stream_mode_definition_q <= reg_req.wdata;
        end
    end

    // a write wins over the analog preset, which only patches two bits
    always_ff @(posedge clk) begin
        if (!nrst || ctx.set_default) begin
            auxiliary_definition_q <= AUX_DEF_RESET;
        end else if (wr_aux) begin
            auxiliary_definition_q <= reg_req.wdata;
        end else if (ctx.analog_preset) begin
            auxiliary_definition_q[TX_MOD_TYPE_BIT] <= ctx.preset_am;
            auxiliary_definition_q[FIELD_DET_BIT] <= ctx.preset_fd;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_req.re) begin
            unique case (reg_req.addr)
                TYPEB_ALT_OFFSET: reg_rdata_q <= typeb_alt_protocol_settings_q;
                STREAM_MODE_OFFSET: reg_rdata_q <= stream_mode_definition_q;
                AUX_DEF_OFFSET: reg_rdata_q <= auxiliary_definition_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // automatic crc-less reception window
    // ------------------------------------------------------------
    // a new reqa/wupa in the cycle the frame ends keeps the window open
    always_ff @(posedge clk) begin
        if (!nrst) begin
            auto_no_crc_q <= 1'b0;
        end else if (ctx.reqa_wupa_sent) begin
            auto_no_crc_q <= 1'b1;
        end else if (ctx.rx_frame_end) begin
            auto_no_crc_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [1:0] mrd_code;
    logic [1:0] pre_code;
    logic [1:0] scf_code;
    logic [1:0] scp_code;
    logic [2:0] stx_code;

    assign mrd_code = typeb_alt_protocol_settings_q[MIN_RESP_DELAY_HI:MIN_RESP_DELAY_LO];
    assign pre_code = typeb_alt_protocol_settings_q[PREAMBLE_LEN_HI:PREAMBLE_LEN_LO];
    assign scf_code = stream_mode_definition_q[SUBCARRIER_FREQ_HI:SUBCARRIER_FREQ_LO];
    assign scp_code = stream_mode_definition_q[REPORT_PULSES_HI:REPORT_PULSES_LO];
    assign stx_code = stream_mode_definition_q[MOD_PERIOD_B2:MOD_PERIOD_B0];

    always_comb begin
        cfg_d = '0;
        // unused delay and period codes give zero figures with valid low
        unique case (mrd_code)
            2'b00: begin
                cfg_d.min_response_delay = MRD_LONG_FS;
                cfg_d.min_response_valid = 1'b1;
            end
            2'b01: begin
                cfg_d.min_response_delay = ctx.rate_fc128 ? MRD_LOW_RATE_FS
                                                          : MRD_HIGH_RATE_FS;
                cfg_d.min_response_valid = 1'b1;
            end
            default: begin
                cfg_d.min_response_delay = 7'h00;
                cfg_d.min_response_valid = 1'b0;
            end
        endcase
        cfg_d.rx_no_sof = typeb_alt_protocol_settings_q[NO_SOF_BIT];
        cfg_d.rx_no_eof = typeb_alt_protocol_settings_q[NO_EOF_BIT];
        cfg_d.eof_min_etu = EOF_MIN_ETU;
        // fast rates cannot tell 11 from 12 etu, so the wide window always holds
        if (ctx.rate_ge_fc16) begin
            cfg_d.eof_max_etu = EOF_WIDE_MAX_ETU;
        end else if (typeb_alt_protocol_settings_q[EOF_WIDE_BIT]) begin
            cfg_d.eof_max_etu = EOF_WIDE_MAX_ETU;
        end else begin
            cfg_d.eof_max_etu = EOF_NARROW_MAX_ETU;
        end
        cfg_d.phase_change_tolerance = typeb_alt_protocol_settings_q[PHASE_TOL_BIT];
        cfg_d.preamble_len = PREAMBLE_BASE + 7'(PREAMBLE_STEP * pre_code);
        if (ctx.bpsk_stream) begin
            cfg_d.subcarrier_div = BPSK_BASE_DIV >> scf_code;
            cfg_d.subcarrier_valid = (scf_code != 2'b11);
        end else begin
            cfg_d.subcarrier_div = SC_BASE_DIV >> scf_code;
            cfg_d.subcarrier_valid = 1'b1;
        end
        cfg_d.report_pulses = PULSES_BASE << scp_code;
        cfg_d.report_valid = ctx.bpsk_stream || (scp_code != 2'b00);
        cfg_d.mod_period_div = (stx_code == 3'b111) ? 8'h00 : (MOD_BASE_DIV >> stx_code);
        cfg_d.mod_period_valid = (stx_code != 3'b111);
        cfg_d.crc_check = !auxiliary_definition_q[CRC_SKIP_BIT]
                          && !auto_no_crc_q && !ctx.anticoll_on;
        cfg_d.crc_to_fifo = auxiliary_definition_q[CRC_FIFO_BIT];
        cfg_d.tx_mod_type = auxiliary_definition_q[TX_MOD_TYPE_BIT];
        cfg_d.field_detector_enable = auxiliary_definition_q[FIELD_DET_BIT];
        cfg_d.rf_output_driver_tristate = auxiliary_definition_q[TRISTATE_BIT]
                                          && ctx.ook_mod_active;
        cfg_d.rx_tol_bpsk = auxiliary_definition_q[RX_TOL_BIT] && ctx.bpsk_fc32;
        cfg_d.rx_tol_first_byte = auxiliary_definition_q[RX_TOL_BIT]
                                  && ctx.typea_nfc_fc128;
        cfg_d.field_on_n = auxiliary_definition_q[FIELD_ON_N_HI:FIELD_ON_N_LO];
    end

    // decoded view lags the registers by one cycle so every output is a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign cfg = cfg_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_write_aux;
        reg_req.we && reg_req.addr == AUX_DEF_OFFSET && !ctx.set_default;
    endsequence

    sequence s_aux_seen;
        ##1 (auxiliary_definition_q == $past(reg_req.wdata)) ##1 1'b1;
    endsequence

    property p_mrd_decode;
        mrd_code == 2'b01 && !ctx.rate_fc128 |=> cfg.min_response_delay == 7'h20;
    endproperty
    a_mrd_decode: assert property (p_mrd_decode)
        else $error("min response delay not 32/fs at high rate");

    // sampled nrst keeps the release edge out, where cfg still reads all zero
    property p_eof_window;
        nrst && !ctx.rate_ge_fc16 && !typeb_alt_protocol_settings_q[EOF_WIDE_BIT]
            |=> cfg.eof_max_etu == 4'hb;
    endproperty
    a_eof_window: assert property (p_eof_window)
        else $error("narrow eof window not 11 etu");

    property p_eof_fast;
        ctx.rate_ge_fc16 |=> cfg.eof_max_etu == 4'hc;
    endproperty
    a_eof_fast: assert property (p_eof_fast)
        else $error("fast rate eof window not widened");

    property p_preamble;
        pre_code == 2'b11 |=> cfg.preamble_len == 7'h60;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("preamble code 11 not 96");

    property p_bpsk_unused;
        ctx.bpsk_stream && scf_code == 2'b11 |=> !cfg.subcarrier_valid;
    endproperty
    a_bpsk_unused: assert property (p_bpsk_unused)
        else $error("bpsk subcarrier code 11 flagged valid");

    property p_mod_period;
        stx_code == 3'b110 |=> cfg.mod_period_div == 8'h02 && cfg.mod_period_valid;
    endproperty
    a_mod_period: assert property (p_mod_period)
        else $error("modulator period code 110 not fc/2");

    property p_stream_keeps;
        ctx.set_default && !wr_stream |=> $stable(stream_mode_definition_q);
    endproperty
    a_stream_keeps: assert property (p_stream_keeps)
        else $error("set default disturbed stream register");

    property p_set_default;
        ctx.set_default |=> typeb_alt_protocol_settings_q == 8'h00
                            && auxiliary_definition_q == 8'h04 ##1 cfg.field_on_n == 2'b00;
    endproperty
    a_set_default: assert property (p_set_default)
        else $error("set default did not reload defaults");

    property p_auto_no_crc;
        ctx.reqa_wupa_sent |=> auto_no_crc_q ##1 !cfg.crc_check;
    endproperty
    a_auto_no_crc: assert property (p_auto_no_crc)
        else $error("crc still checked after reqa or wupa");

    property p_aux_write;
        s_write_aux |-> s_aux_seen;
    endproperty
    a_aux_write: assert property (p_aux_write)
        else $error("auxiliary write not stored");

    property p_tristate;
        ##1 cfg.rf_output_driver_tristate |-> $past(ctx.ook_mod_active)
                                             && $past(auxiliary_definition_q[TRISTATE_BIT]);
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("drivers floated outside ook");

    property p_readback;
        reg_req.re && reg_req.addr == STREAM_MODE_OFFSET
            |=> reg_rdata == $past(stream_mode_definition_q);
    endproperty
    a_readback: assert property (p_readback)
        else $error("stream register readback mismatch");

    property p_no_sof;
        nrst |=> cfg.rx_no_sof == $past(typeb_alt_protocol_settings_q[NO_SOF_BIT]);
    endproperty
    a_no_sof: assert property (p_no_sof)
        else $error("sof omission not passed to framer");

    property p_no_eof;
        nrst |=> cfg.rx_no_eof == $past(typeb_alt_protocol_settings_q[NO_EOF_BIT]);
    endproperty
    a_no_eof: assert property (p_no_eof)
        else $error("eof omission not passed to framer");

    property p_phase_tol;
        nrst |=> cfg.phase_change_tolerance
                 == $past(typeb_alt_protocol_settings_q[PHASE_TOL_BIT]);
    endproperty
    a_phase_tol: assert property (p_phase_tol)
        else $error("phase tolerance not passed to demodulator");

    property p_pulses;
        scp_code == 2'b11 |=> cfg.report_pulses == 4'h8 && cfg.report_valid;
    endproperty
    a_pulses: assert property (p_pulses)
        else $error("pulse code 11 not 8 pulses");

    property p_crc_skip;
        auxiliary_definition_q[CRC_SKIP_BIT] |=> !cfg.crc_check;
    endproperty
    a_crc_skip: assert property (p_crc_skip)
        else $error("crc still checked with skip bit set");

    property p_crc_fifo;
        nrst |=> cfg.crc_to_fifo == $past(auxiliary_definition_q[CRC_FIFO_BIT]);
    endproperty
    a_crc_fifo: assert property (p_crc_fifo)
        else $error("crc to fifo flag not passed on");

    property p_preset;
        ctx.analog_preset && !wr_aux && !ctx.set_default
            |=> auxiliary_definition_q[TX_MOD_TYPE_BIT] == $past(ctx.preset_am);
    endproperty
    a_preset: assert property (p_preset)
        else $error("analog preset did not set modulation type");

    property p_field_det;
        nrst |=> cfg.field_detector_enable == $past(auxiliary_definition_q[FIELD_DET_BIT]);
    endproperty
    a_field_det: assert property (p_field_det)
        else $error("field detector enable not passed on");

    property p_rx_tol;
        nrst |=> cfg.rx_tol_first_byte
                 == ($past(auxiliary_definition_q[RX_TOL_BIT]) && $past(ctx.typea_nfc_fc128));
    endproperty
    a_rx_tol: assert property (p_rx_tol)
        else $error("first byte tolerance wrong");

    property p_field_on_n;
        nrst |=> cfg.field_on_n == $past(auxiliary_definition_q[FIELD_ON_N_HI:FIELD_ON_N_LO]);
    endproperty
    a_field_on_n: assert property (p_field_on_n)
        else $error("field-on n value not passed on");

endmodule : rf_framing_option_regs

//--- rf_ctx_model.sv
// model of the rf side context: bit rate, stream mode and frame events
`timescale 1ns/1ns
module rf_ctx_model
    import rf_framing_pkg::*;
(
    input wire logic clk,
    output rf_ctx_s ctx
);
    initial begin
        ctx = '0;
    end

    // levels change just after an edge and stand until the next call
    task drive(input rf_ctx_s lv);
        @(posedge clk);
        ctx <= lv;
    endtask : drive

    // events last one cycle on top of the standing levels
    task pulse(input rf_ctx_s ev);
        @(posedge clk);
        ctx <= ctx | ev;
        @(posedge clk);
        ctx <= ctx & ~ev;
    endtask : pulse
endmodule : rf_ctx_model

//--- testbench.sv
// register and decode tests of the framing option register bank
`timescale 1ns/1ns
module testbench
    import rf_framing_pkg::*;
;
    logic clk;
    logic nrst;
    reg_req_s reg_req;
    rf_ctx_s ctx;
    rf_ctx_s lv;
    rf_ctx_s ev;
    logic [7:0] reg_rdata;
    cfg_s cfg;
    int err_total = 0;
    int checked = 0;
    int r;
    int b;
    int c;
    int m;

    rf_framing_option_regs i_rf_framing_option_regs (.clk(clk), .nrst(nrst), .reg_req(reg_req),
        .ctx(ctx), .reg_rdata(reg_rdata), .cfg(cfg));
    rf_ctx_model i_rf_ctx_model (.clk(clk), .ctx(ctx));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a write leaves the strobe up; follow it with rd, wr or settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1 chk("read data", exp, reg_rdata);
        @(posedge clk);
        #1 chk("read idle", 8'h00, reg_rdata);
    endtask : rd

    // cfg trails a write by two edges
    task settle;
        @(posedge clk);
        reg_req <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task results;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        results;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        reg_req = '0;
        lv = '0;
        lv.rate_fc128 = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        i_rf_ctx_model.drive(lv);
        settle;
        rd(TYPEB_ALT_OFFSET, 8'h00);
        rd(STREAM_MODE_OFFSET, 8'h00);
        rd(AUX_DEF_OFFSET, 8'h04);
        chk("crc check", 8'h01, {7'h00, cfg.crc_check});
        for (r = 0; r < 2; r++) begin
            lv.rate_fc128 = (r == 0);
            i_rf_ctx_model.drive(lv);
            for (c = 0; c < 4; c++) begin
                wr(8'h07, {2'(c), 4'h0, 2'(c)});
                settle;
                chk("min delay", (c == 0) ? 8'h50 : (c == 1) ? (r == 0 ? 8'h40 : 8'h20) : 8'h00,
                    {1'b0, cfg.min_response_delay});
                chk("delay valid", 8'(c < 2), {7'h00, cfg.min_response_valid});
                chk("preamble", 8'(8'h30 + 8'h10 * c), {1'b0, cfg.preamble_len});
            end
        end
        for (r = 0; r < 2; r++) begin
            for (b = 0; b < 2; b++) begin
                lv.rate_ge_fc16 = (r == 1);
                i_rf_ctx_model.drive(lv);
                wr(8'h07, (b == 1) ? 8'h3c : 8'h00);
                settle;
                chk("eof max", (r == 1 || b == 1) ? 8'h0c : 8'h0b, {4'h0, cfg.eof_max_etu});
                chk("eof min", 8'h0a, {4'h0, cfg.eof_min_etu});
                chk("no sof", 8'(b), {7'h00, cfg.rx_no_sof});
                chk("no eof", 8'(b), {7'h00, cfg.rx_no_eof});
                chk("phase tol", 8'(b), {7'h00, cfg.phase_change_tolerance});
            end
        end
        for (m = 0; m < 2; m++) begin
            lv.bpsk_stream = (m == 1);
            i_rf_ctx_model.drive(lv);
            for (c = 0; c < 8; c++) begin
                wr(8'h08, {1'(c), 2'(c), 2'(c), 3'(c)});
                settle;
                if (!(m == 1 && c % 4 == 3)) begin
                    chk("sc div", (m == 1 ? 8'h10 : 8'h40) >> (c % 4), cfg.subcarrier_div);
                end
                chk("sc valid", 8'(m == 0 || c % 4 != 3), {7'h00, cfg.subcarrier_valid});
                chk("pulses", 8'h01 << (c % 4), {4'h0, cfg.report_pulses});
                chk("pulse valid", 8'(m == 1 || c % 4 != 0), {7'h00, cfg.report_valid});
                chk("mod div", (c < 7) ? 8'h80 >> c : 8'h00, cfg.mod_period_div);
                chk("mod valid", 8'(c < 7), {7'h00, cfg.mod_period_valid});
                rd(8'h08, {1'(c), 2'(c), 2'(c), 3'(c)});
            end
        end
        lv = '0;
        lv.bpsk_fc32 = 1'b1;
        lv.ook_mod_active = 1'b1;
        i_rf_ctx_model.drive(lv);
        wr(8'h09, 8'h7e);
        settle;
        chk("crc kept", 8'h01, {7'h00, cfg.crc_check});
        chk("crc fifo", 8'h01, {7'h00, cfg.crc_to_fifo});
        chk("mod am", 8'h01, {7'h00, cfg.tx_mod_type});
        chk("field det", 8'h01, {7'h00, cfg.field_detector_enable});
        chk("tristate", 8'h01, {7'h00, cfg.rf_output_driver_tristate});
        chk("tol bpsk", 8'h01, {7'h00, cfg.rx_tol_bpsk});
        chk("tol byte", 8'h00, {7'h00, cfg.rx_tol_first_byte});
        chk("n", 8'h02, {6'h00, cfg.field_on_n});
        lv = '0;
        lv.typea_nfc_fc128 = 1'b1;
        i_rf_ctx_model.drive(lv);
        wr(8'h09, 8'h8d);
        settle;
        chk("crc skip", 8'h00, {7'h00, cfg.crc_check});
        chk("mod ook", 8'h00, {7'h00, cfg.tx_mod_type});
        chk("tristate", 8'h00, {7'h00, cfg.rf_output_driver_tristate});
        chk("tol bpsk", 8'h00, {7'h00, cfg.rx_tol_bpsk});
        chk("tol byte", 8'h01, {7'h00, cfg.rx_tol_first_byte});
        chk("n", 8'h01, {6'h00, cfg.field_on_n});
        wr(8'h09, 8'h00);
        settle;
        ev = '0;
        ev.reqa_wupa_sent = 1'b1;
        i_rf_ctx_model.pulse(ev);
        settle;
        chk("auto no crc", 8'h00, {7'h00, cfg.crc_check});
        ev = '0;
        ev.rx_frame_end = 1'b1;
        i_rf_ctx_model.pulse(ev);
        settle;
        chk("crc back", 8'h01, {7'h00, cfg.crc_check});
        lv.anticoll_on = 1'b1;
        i_rf_ctx_model.drive(lv);
        settle;
        chk("anticoll crc", 8'h00, {7'h00, cfg.crc_check});
        ev = '0;
        ev.analog_preset = 1'b1;
        ev.preset_fd = 1'b1;
        ev.preset_am = 1'b1;
        i_rf_ctx_model.pulse(ev);
        settle;
        chk("preset fd", 8'h01, {7'h00, cfg.field_detector_enable});
        chk("preset am", 8'h01, {7'h00, cfg.tx_mod_type});
        rd(8'h09, 8'h30);
        fork
            // drop the strobe after one edge so the write is taken once only
            begin
                wr(8'h09, 8'h20);
                @(posedge clk);
                reg_req <= '0;
            end
            i_rf_ctx_model.pulse(ev);
        join
        settle;
        rd(8'h09, 8'h20);
        // ------------------------------------------------------------
        // defaults and unmapped places
        // ------------------------------------------------------------
        wr(8'h08, 8'ha5);
        wr(8'h07, 8'hff);
        wr(8'h09, 8'hfb);
        settle;
        ev = '0;
        ev.set_default = 1'b1;
        i_rf_ctx_model.pulse(ev);
        settle;
        rd(8'h07, 8'h00);
        rd(8'h09, 8'h04);
        rd(8'h08, 8'ha5);
        fork
            begin
                wr(8'h07, 8'h55);
                @(posedge clk);
                reg_req <= '0;
            end
            i_rf_ctx_model.pulse(ev);
        join
        settle;
        rd(8'h07, 8'h00);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h09, 8'h04);
        // mid-run power-up reset clears the stream register too
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h04);
        results;
    end
endmodule : testbench
